/* design/ufc_pkg.sv */
// Register map, limits, timing and carrier types of the UART flow control block
package ufc_pkg;
   // Register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_BAUD = 8'h04;
   localparam logic [7:0] OFF_CLKDIV = 8'h08;
   localparam logic [7:0] OFF_HWMARK = 8'h0C;
   localparam logic [7:0] OFF_XLIM = 8'h10;
   localparam logic [7:0] OFF_XCHAR = 8'h14;
   localparam logic [7:0] OFF_RSTIME = 8'h18;
   localparam logic [7:0] OFF_IMM = 8'h1C;
   localparam logic [7:0] OFF_STAT = 8'h20;
   localparam logic [7:0] OFF_XEFF = 8'h24;
   // Control bit positions
   localparam int B_HW = 32'h0000_0000;
   localparam int B_SW = 32'h0000_0001;
   localparam int B_BYP = 32'h0000_0002;
   localparam int B_RTSTX = 32'h0000_0003;
   localparam int B_485 = 32'h0000_0004;
   localparam int B_485LOW = 32'h0000_0005;
   localparam int B_CLK = 32'h0000_0006;
   localparam int B_MODEM = 32'h0000_0007;
   localparam int B_DTR = 32'h0000_0008;
   localparam int B_WAKE = 32'h0000_0009;
   // Upper field position in the mark and limit registers
   localparam int F_HI = 32'h0000_0010;
   // Reset values
   localparam logic [9:0] RST_CTRL = 10'h000;
   localparam logic [23:0] RST_BAUD = 24'h01_C200;
   localparam logic [7:0] RST_CLKDIV = 8'h00;
   localparam logic [31:0] RST_HWMARK = 32'h0180_01C0;
   localparam logic [31:0] RST_XLIM = 32'h00C0_00C0;
   localparam logic [15:0] RST_XCHAR = 16'h1311;
   localparam logic [15:0] RST_RSTIME = 16'h0000;
   // Fill levels and limits
   localparam logic [9:0] FIFO_DEPTH = 10'h200;
   localparam logic [15:0] LIM_MAX = 16'h0200;
   localparam logic [9:0] XON_NORM = 10'h1C0;
   localparam logic [9:0] XOFF_NORM = 10'h200;
   localparam logic [9:0] XOFF_ZERO = 10'h040;
   // Baud thresholds
   localparam logic [23:0] BAUD_TX_MIN = 24'h00_04B0;
   localparam logic [23:0] BAUD_PRE_MAX = 24'h00_016D;
   localparam logic [23:0] BAUD_FLOW_MAX = 24'h0F_4240;
   // Timing
   localparam int CLK_PERIOD_NS = 32'h0000_0014;
   localparam int LED_HALF_NS = 32'h02FA_F080;
   localparam int LED_HALF_CYC = LED_HALF_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ufc_bus_t;

   typedef struct packed {
      logic start;
      logic [7:0] data;
   } ufc_txb_t;

   typedef enum logic [3:0] {
      D_IDLE = 4'b0001,
      D_SETUP = 4'b0010,
      D_ON = 4'b0100,
      D_HOLD = 4'b1000
   } ufc_dir_t;
endpackage : ufc_pkg

/* design/ufc_top.sv */
// UART flow control, transmit arbitration and auxiliary pin logic
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// What this block does
// R1 - Wake pin falling edge in suspend starts wakeup
// R2 - Clock output is clock over twice (N+1)
// R3 - Clock output stops during USB suspend
// R4 - RTS high once receive level reaches stop mark
// R5 - RTS stays high until level drains to resume
// R6 - Far end stops sending while RTS high
// R7 - RTS follows transmission in transmit mode, 1200+
// R8 - CTS high stops new bytes, two at most
// R9 - Received XOFF halts, XON resumes transmission
// R10 - Bypass lets own XON/XOFF out while halted
// R11 - Limits above 512 become 448 and 512
// R12 - XON limit clipped to XOFF limit
// R13 - XOFF limit zero becomes 64
// R14 - Software keeps limit sum below 512
// R15 - Stop at stop mark, continue at resume (hardware) or below it (software)
// R16 - Flow control forced above 1 MBaud
// R17 - Events post only with free FIFO space
// R18 - Immediate character goes ahead of queue
// R19 - Activity LEDs toggle on traffic, idle high
// R20 - Modem lines only when enabled, active low
// R21 - Direction pin with polarity, setup and hold
// R22 - No direction pin below 1200 baud
// R23 - Prescale 4 at or below 365 baud
// R24 - LED toggle period is a parameter
// R25 - Flow characters and limits live in registers
module ufc_top #(
   parameter int LED_HALF_CYC = ufc_pkg::LED_HALF_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire ufc_pkg::ufc_bus_t bus,
   output logic [31:0] rd_data_q,
   input wire logic usb_suspend,
   input wire logic [9:0] rx_level,
   input wire logic rx_stb,
   input wire logic [7:0] rx_byte,
   input wire logic txq_valid,
   input wire logic [7:0] txq_data,
   output logic txq_pop_q,
   output ufc_pkg::ufc_txb_t txb_q,
   input wire logic txs_busy,
   input wire logic evt_req,
   output logic evt_post_q,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic dcd_n,
   input wire logic ri_n,
   input wire logic remote_wake_n,
   output logic rts_n_q,
   output logic dtr_n_q,
   output logic transceiver_dir,
   output logic clk_out_q,
   output logic wake_req_q,
   output logic prescale4_q,
   output logic tx_activity_led,
   output logic rx_activity_led
);

   logic [9:0] ctrl_q;
   logic [23:0] baud_q;
   logic [7:0] clkdiv_q;
   logic [31:0] hwmark_q;
   logic [31:0] xlim_q;
   logic [15:0] xchar_q;
   logic [15:0] rstime_q;
   logic [4:0] pin_m_q;
   logic [4:0] pin_s_q;
   logic wake_p_q;
   logic rts_stop_q;
   logic sw_stop_q;
   logic pend_off_q;
   logic pend_on_q;
   logic halted_q;
   logic imm_pend_q;
   logic [7:0] imm_char_q;
   logic evt_pend_q;
   logic [7:0] ccnt_q;
   logic [7:0] dcnt_q;
   logic [31:0] lcnt_q;
   ufc_pkg::ufc_dir_t dir_st_q;
   logic [9:0] xon_e;
   logic [9:0] xoff_e;
   logic [9:0] hw_stop;
   logic [9:0] hw_resume;
   logic [7:0] xon_c;
   logic [7:0] xoff_c;
   logic ge1200;
   logic hw_eff;
   logic rtstx;
   logic rs_on;
   logic cts_blk;
   logic tx_free;
   logic ctl_ok;
   logic dat_ok;
   logic want;
   logic dir_rdy;
   logic go;
   logic send_ctl;
   logic send_imm;
   logic send_q;
   logic post_now;
   logic ltick;
   logic imm_wr;
   logic [1:0] led_stb;
   logic [1:0] led_v;

   assign hw_stop = hwmark_q[9:0];
   assign hw_resume = hwmark_q[ufc_pkg::F_HI +: 10];
   assign xon_c = xchar_q[7:0];
   assign xoff_c = xchar_q[15:8];
   assign ge1200 = baud_q >= ufc_pkg::BAUD_TX_MIN;
   assign rs_on = ctrl_q[ufc_pkg::B_485] && ge1200; // [R22]
   assign rtstx = ctrl_q[ufc_pkg::B_RTSTX] && ge1200; // [R7]
   // Above 1 MBaud hardware flow is forced unless software flow is on
   assign hw_eff = ctrl_q[ufc_pkg::B_HW] ||
                   (baud_q > ufc_pkg::BAUD_FLOW_MAX && !ctrl_q[ufc_pkg::B_SW]); // [R16]
   assign cts_blk = hw_eff && pin_s_q[0];
   assign imm_wr = bus.wr && bus.addr == ufc_pkg::OFF_IMM;

   // Two-flop synchronisers for all pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_m_q <= 5'h1F;
         pin_s_q <= 5'h1F;
      end else begin
         pin_m_q <= {remote_wake_n, ri_n, dcd_n, dsr_n, cts_n};
         pin_s_q <= pin_m_q;
      end
   end

   // Configuration registers, applied without resetting the UART
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= ufc_pkg::RST_CTRL;
         baud_q <= ufc_pkg::RST_BAUD;
         clkdiv_q <= ufc_pkg::RST_CLKDIV;
         hwmark_q <= ufc_pkg::RST_HWMARK;
         xlim_q <= ufc_pkg::RST_XLIM;
         xchar_q <= ufc_pkg::RST_XCHAR;
         rstime_q <= ufc_pkg::RST_RSTIME;
      end else if (bus.wr) begin
         case (bus.addr)
            ufc_pkg::OFF_CTRL: ctrl_q <= bus.wdata[9:0];
            ufc_pkg::OFF_BAUD: baud_q <= bus.wdata[23:0];
            ufc_pkg::OFF_CLKDIV: clkdiv_q <= bus.wdata[7:0]; // [R2]
            ufc_pkg::OFF_HWMARK: hwmark_q <= bus.wdata;
            ufc_pkg::OFF_XLIM: xlim_q <= bus.wdata; // [R25]
            ufc_pkg::OFF_XCHAR: xchar_q <= bus.wdata[15:0]; // [R25]
            ufc_pkg::OFF_RSTIME: rstime_q <= bus.wdata[15:0];
            default: ;
         endcase
      end
   end

   // Read data for the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (sys_rst || !bus.rd) begin
         rd_data_q <= 32'h0000_0000;
      end else begin
         case (bus.addr)
            ufc_pkg::OFF_CTRL: rd_data_q <= {22'h00_0000, ctrl_q};
            ufc_pkg::OFF_BAUD: rd_data_q <= {8'h00, baud_q};
            ufc_pkg::OFF_CLKDIV: rd_data_q <= {24'h00_0000, clkdiv_q};
            ufc_pkg::OFF_HWMARK: rd_data_q <= hwmark_q;
            ufc_pkg::OFF_XLIM: rd_data_q <= xlim_q;
            ufc_pkg::OFF_XCHAR: rd_data_q <= {16'h0000, xchar_q};
            ufc_pkg::OFF_RSTIME: rd_data_q <= {16'h0000, rstime_q};
            ufc_pkg::OFF_IMM: rd_data_q <= {23'h00_0000, imm_pend_q, imm_char_q};
            ufc_pkg::OFF_STAT: begin
               rd_data_q <= {19'h0_0000, prescale4_q, evt_pend_q, usb_suspend,
                             ctrl_q[ufc_pkg::B_MODEM] ? ~pin_s_q[3:1] : 3'h0, // [R20]
                             ~pin_s_q[0], halted_q, sw_stop_q, pend_off_q, pend_on_q,
                             dir_st_q == ufc_pkg::D_ON, rts_n_q};
            end
            ufc_pkg::OFF_XEFF: rd_data_q <= {6'h00, xoff_e, 6'h00, xon_e};
            default: rd_data_q <= 32'h0000_0000;
         endcase
      end
   end

   // Normalised software handshake limits
   always_comb begin
      xon_e = xlim_q[9:0];
      xoff_e = xlim_q[ufc_pkg::F_HI +: 10];
      if (xlim_q[15:0] > ufc_pkg::LIM_MAX || xlim_q[31:16] > ufc_pkg::LIM_MAX) begin
         xon_e = ufc_pkg::XON_NORM; // [R11]
         xoff_e = ufc_pkg::XOFF_NORM; // [R11]
      end else begin
         if (xlim_q[31:16] == 16'h0000) begin
            xoff_e = ufc_pkg::XOFF_ZERO; // [R13]
         end
         if (xon_e > xoff_e) begin
            xon_e = xoff_e; // [R12]
         end
      end
   end

   // RTS: transmit-follow mode, or hysteresis on the receive level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rts_n_q <= 1'b0;
         rts_stop_q <= 1'b0;
      end else if (rtstx) begin
         rts_n_q <= !(txs_busy || txb_q.start); // [R7]
         rts_stop_q <= 1'b0;
      end else if (!hw_eff) begin
         rts_n_q <= 1'b0;
         rts_stop_q <= 1'b0;
      end else if (rx_level >= hw_stop) begin
         rts_n_q <= 1'b1; // [R4] [R15]
         rts_stop_q <= 1'b1;
      end else if (rts_stop_q && rx_level <= hw_resume) begin
         rts_n_q <= 1'b0; // [R5] [R15]
         rts_stop_q <= 1'b0;
      end else begin
         rts_n_q <= rts_stop_q; // [R5]
      end
   end

   // Software handshake: request XOFF at the stop limit, XON below resume
   always_ff @(posedge clk) begin
      if (sys_rst || !ctrl_q[ufc_pkg::B_SW]) begin
         sw_stop_q <= 1'b0;
         pend_off_q <= 1'b0;
         pend_on_q <= 1'b0;
      end else if (!sw_stop_q && rx_level >= xoff_e) begin
         sw_stop_q <= 1'b1; // [R15]
         pend_off_q <= 1'b1;
         pend_on_q <= 1'b0;
      end else if (sw_stop_q && rx_level < xon_e) begin
         sw_stop_q <= 1'b0; // [R15]
         pend_on_q <= 1'b1;
         pend_off_q <= 1'b0;
      end else if (send_ctl) begin
         pend_off_q <= 1'b0;
         pend_on_q <= 1'b0;
      end
   end

   // Halt on a received XOFF, resume on XON
   always_ff @(posedge clk) begin
      if (sys_rst || !ctrl_q[ufc_pkg::B_SW]) begin
         halted_q <= 1'b0;
      end else if (rx_stb && rx_byte == xoff_c) begin
         halted_q <= 1'b1; // [R9]
      end else if (rx_stb && rx_byte == xon_c) begin
         halted_q <= 1'b0; // [R9]
      end
   end

   // Immediate character request; a new write wins over the send
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         imm_pend_q <= 1'b0;
         imm_char_q <= 8'h00;
      end else if (imm_wr) begin
         imm_pend_q <= 1'b1;
         imm_char_q <= bus.wdata[7:0];
      end else if (send_imm) begin
         imm_pend_q <= 1'b0;
      end
   end

   // Transmit arbitration: flow character, then immediate, then queue
   always_comb begin
      tx_free = !txs_busy && !txb_q.start;
      ctl_ok = (pend_off_q || pend_on_q) && (!halted_q || ctrl_q[ufc_pkg::B_BYP]); // [R9] [R10]
      dat_ok = !halted_q && !cts_blk; // [R8] [R9]
      want = ctl_ok || (dat_ok && (imm_pend_q || txq_valid));
      dir_rdy = !rs_on || dir_st_q == ufc_pkg::D_ON; // [R21]
      go = want && tx_free && dir_rdy;
      send_ctl = go && ctl_ok;
      send_imm = go && !ctl_ok && imm_pend_q; // [R18]
      send_q = go && !ctl_ok && !imm_pend_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txb_q <= '0;
         txq_pop_q <= 1'b0;
      end else begin
         txb_q.start <= go;
         txq_pop_q <= send_q;
         if (send_ctl) begin
            txb_q.data <= pend_off_q ? xoff_c : xon_c;
         end else if (send_imm) begin
            txb_q.data <= imm_char_q; // [R18]
         end else if (send_q) begin
            txb_q.data <= txq_data;
         end
      end
   end

   // Transceiver direction with programmable setup and hold
   always_ff @(posedge clk) begin
      if (sys_rst || !rs_on) begin
         dir_st_q <= ufc_pkg::D_IDLE; // [R22]
         dcnt_q <= 8'h00;
      end else begin
         unique case (dir_st_q)
            ufc_pkg::D_IDLE: begin
               dcnt_q <= 8'h00;
               if (want) begin
                  dir_st_q <= ufc_pkg::D_SETUP;
               end
            end
            ufc_pkg::D_SETUP: begin
               if (dcnt_q >= rstime_q[7:0]) begin
                  dir_st_q <= ufc_pkg::D_ON; // [R21]
               end else begin
                  dcnt_q <= dcnt_q + 8'h01;
               end
            end
            ufc_pkg::D_ON: begin
               dcnt_q <= 8'h00;
               if (!want && tx_free) begin
                  dir_st_q <= ufc_pkg::D_HOLD;
               end
            end
            ufc_pkg::D_HOLD: begin
               if (want) begin
                  dir_st_q <= ufc_pkg::D_ON;
               end else if (dcnt_q >= rstime_q[15:8]) begin
                  dir_st_q <= ufc_pkg::D_IDLE; // [R21]
               end else begin
                  dcnt_q <= dcnt_q + 8'h01;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         transceiver_dir <= 1'b0;
      end else begin
         transceiver_dir <= (dir_st_q != ufc_pkg::D_IDLE) ^ ctrl_q[ufc_pkg::B_485LOW]; // [R21]
      end
   end

   // Divided clock output, held low in suspend
   always_ff @(posedge clk) begin
      if (sys_rst || usb_suspend || !ctrl_q[ufc_pkg::B_CLK]) begin
         ccnt_q <= 8'h00; // [R3]
         clk_out_q <= 1'b0; // [R3]
      end else if (ccnt_q >= clkdiv_q) begin
         ccnt_q <= 8'h00; // [R2]
         clk_out_q <= ~clk_out_q; // [R2]
      end else begin
         ccnt_q <= ccnt_q + 8'h01;
      end
   end

   // Remote wakeup on a falling wake pin during suspend
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_p_q <= 1'b1;
         wake_req_q <= 1'b0;
      end else begin
         wake_p_q <= pin_s_q[4];
         wake_req_q <= ctrl_q[ufc_pkg::B_WAKE] && usb_suspend && wake_p_q && !pin_s_q[4]; // [R1]
      end
   end

   // Event posting waits for receive FIFO space; a new event wins
   assign post_now = evt_pend_q && rx_level < ufc_pkg::FIFO_DEPTH; // [R17]
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_pend_q <= 1'b0;
         evt_post_q <= 1'b0;
      end else begin
         evt_pend_q <= evt_req || (evt_pend_q && !post_now);
         evt_post_q <= post_now; // [R17]
      end
   end

   // Modem output and baud prescale
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dtr_n_q <= 1'b1;
         prescale4_q <= 1'b0;
      end else begin
         dtr_n_q <= !(ctrl_q[ufc_pkg::B_MODEM] && ctrl_q[ufc_pkg::B_DTR]); // [R20]
         prescale4_q <= baud_q <= ufc_pkg::BAUD_PRE_MAX; // [R23]
      end
   end

   // Activity LED half-period tick
   assign ltick = lcnt_q >= 32'(LED_HALF_CYC - 1); // [R24]
   always_ff @(posedge clk) begin
      if (sys_rst || ltick) begin
         lcnt_q <= 32'h0000_0000;
      end else begin
         lcnt_q <= lcnt_q + 32'h0000_0001;
      end
   end

   assign led_stb = {rx_stb, txb_q.start};
   for (genvar i = 0; i < 2; i++) begin : g_led
      logic led_q;
      logic act_q;
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            led_q <= 1'b1;
            act_q <= 1'b0;
         end else begin
            if (ltick && (act_q || !led_q)) begin
               led_q <= ~led_q; // [R19]
            end
            if (led_stb[i]) begin
               act_q <= 1'b1;
            end else if (ltick && !led_q) begin
               act_q <= 1'b0;
            end
         end
      end
      assign led_v[i] = led_q;
   end
   assign tx_activity_led = led_v[0];
   assign rx_activity_led = led_v[1];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_xoff_rx;
      rx_stb && rx_byte == xoff_c && ctrl_q[ufc_pkg::B_SW];
   endsequence

   sequence s_ctl_halted;
      txb_q.start && $past(halted_q);
   endsequence

   rts_stop_a: assert property ((hw_eff && !rtstx && rx_level >= hw_stop) |=> rts_n_q) // [R4]
      else $error("rts not raised at stop mark");
   rts_hold_a: assert property ((hw_eff && !rtstx && rts_n_q && rx_level > hw_resume) |=> rts_n_q) // [R5]
      else $error("rts dropped above resume mark");
   cts_gate_a: assert property (txq_pop_q |-> $past(!cts_blk)) // [R8]
      else $error("queue byte started while cts high");
   halt_rx_a: assert property (s_xoff_rx |=> halted_q) // [R9]
      else $error("xoff did not halt");
   halt_tx_a: assert property (txq_pop_q |-> !$past(halted_q)) // [R9]
      else $error("queue byte sent while halted");
   bypass_ctl_a: assert property (s_ctl_halted |-> $past(ctrl_q[ufc_pkg::B_BYP])) // [R10]
      else $error("send while halted without bypass");
   imm_first_a: assert property (txq_pop_q |-> !$past(imm_pend_q)) // [R18]
      else $error("queue passed immediate char");
   xlim_norm_a: assert property (xoff_e != 10'h000 && xoff_e <= ufc_pkg::XOFF_NORM && xon_e <= xoff_e) // [R12]
      else $error("limits not normalised");
   clk_stop_a: assert property (usb_suspend |=> !clk_out_q ##1 !clk_out_q || !usb_suspend) // [R3]
      else $error("clock ran in suspend");
   wake_cause_a: assert property (wake_req_q |-> $past(usb_suspend) && $past(pin_s_q[4], 2)) // [R1]
      else $error("wake without suspend edge");
   dir_on_a: assert property ((txb_q.start && rs_on) |-> dir_st_q == ufc_pkg::D_ON) // [R21]
      else $error("byte started without direction");

endmodule : ufc_top

/* verification/ufc_far_end.sv */
// Far-end UART model: byte shifter timing and a sender that obeys RTS
`timescale 1ns/1ns
module ufc_far_end #(
   parameter int BUSY_CYC = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire ufc_pkg::ufc_txb_t txb,
   input wire logic rts_n,
   input wire logic send,
   input wire logic [7:0] send_byte,
   output logic txs_busy,
   output logic rx_stb,
   output logic [7:0] rx_byte,
   output int tx_count,
   output logic [7:0] tx_last
);
   int busy_cnt;
   logic pend;
   logic [7:0] pend_byte;
   // Shifter busy from the cycle after start until the byte is out
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_cnt <= 0;
         tx_count <= 0;
         tx_last <= 8'h00;
      end else if (txb.start) begin
         busy_cnt <= BUSY_CYC;
         tx_count <= tx_count + 1;
         tx_last <= txb.data;
      end else if (busy_cnt != 0) begin
         busy_cnt <= busy_cnt - 1;
      end
   end
   assign txs_busy = (busy_cnt != 0);
   // Sender holds its byte while RTS is high; idle data line is scrambled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pend <= 1'b0;
         pend_byte <= 8'h00;
         rx_stb <= 1'b0;
         rx_byte <= 8'h00;
      end else begin
         rx_stb <= 1'b0;
         rx_byte <= ~rx_byte;
         if (send) begin
            pend <= 1'b1;
            pend_byte <= send_byte;
         end else if (pend && !rts_n) begin
            rx_stb <= 1'b1;
            rx_byte <= pend_byte;
            pend <= 1'b0;
         end
      end
   end
endmodule : ufc_far_end

/* verification/ufc_top_bench.sv */
// Self-checking bench for the UART flow control block
`timescale 1ns/1ns
module ufc_top_bench;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   ufc_pkg::ufc_bus_t bus = '0;
   logic usb_suspend = 1'b0;
   logic [9:0] rx_level = 10'h000;
   logic txq_valid = 1'b0;
   logic [7:0] txq_data = 8'h00;
   logic cts_n = 1'b0, evt_req = 1'b0;
   logic remote_wake_n = 1'b1;
   logic send = 1'b0;
   logic [7:0] send_byte = 8'h00;
   logic [31:0] rd_data_q, v;
   logic rx_stb, txq_pop_q, txs_busy, evt_post_q, rts_n_q, dtr_n_q, transceiver_dir, clk_out_q, wake_req_q;
   logic prescale4_q, tx_led, rx_led, tx_low, rx_low, dir_at_start, seen;
   logic [7:0] rx_byte, tx_last;
   ufc_pkg::ufc_txb_t txb_q;
   int tx_count, c, n;
   int fail_count = 0;
   int num_checks = 0;
   logic [9:0] lv [5] = '{10'h1BF, 10'h1C0, 10'h181, 10'h180, 10'h000};
   logic rts_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [31:0] xl [3] = '{32'h0258_0258, 32'h0000_0020, 32'h00C8_012C};
   logic [31:0] xe [3] = '{32'h0200_01C0, 32'h0040_0020, 32'h00C8_00C8};
   logic [7:0] dv [3] = '{8'hFF, 8'h02, 8'h00};

   always #10 clk = ~clk;
   always @(posedge clk) begin
      if (tx_led === 1'b0) tx_low <= 1'b1;
      if (rx_led === 1'b0) rx_low <= 1'b1;
      if (txb_q.start === 1'b1) dir_at_start <= transceiver_dir;
   end

   ufc_top #(.LED_HALF_CYC(4)) uut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rd_data_q(rd_data_q),
      .usb_suspend(usb_suspend), .rx_level(rx_level), .rx_stb(rx_stb), .rx_byte(rx_byte),
      .txq_valid(txq_valid), .txq_data(txq_data), .txq_pop_q(txq_pop_q), .txb_q(txb_q), .txs_busy(txs_busy),
      .evt_req(evt_req), .evt_post_q(evt_post_q), .cts_n(cts_n), .dsr_n(1'b0), .dcd_n(1'b1), .ri_n(1'b1),
      .remote_wake_n(remote_wake_n), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q), .transceiver_dir(transceiver_dir),
      .clk_out_q(clk_out_q), .wake_req_q(wake_req_q), .prescale4_q(prescale4_q), .tx_activity_led(tx_led),
      .rx_activity_led(rx_led));
   ufc_far_end #(.BUSY_CYC(8)) far (.clk(clk), .sys_rst(sys_rst), .txb(txb_q), .rts_n(rts_n_q), .send(send),
      .send_byte(send_byte), .txs_busy(txs_busy), .rx_stb(rx_stb), .rx_byte(rx_byte), .tx_count(tx_count),
      .tx_last(tx_last));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 d = rd_data_q;
   endtask : rd
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task automatic wait_tx(input int k);
      n = 0;
      while (tx_count < k && n < 300) begin
         step(1);
         n++;
      end
      chk(n < 300, 1);
   endtask : wait_tx
   task automatic send_rx(input logic [7:0] b);
      @(posedge clk);
      send <= 1'b1;
      send_byte <= b;
      @(posedge clk);
      send <= 1'b0;
      step(6);
   endtask : send_rx
   task automatic edge_gap(output int g);
      logic s;
      step(1);
      s = clk_out_q;
      for (int i = 0; i < 2; i++) begin
         g = 0;
         while (clk_out_q === s && g < 600) begin
            step(1);
            g++;
         end
         s = clk_out_q;
      end
   endtask : edge_gap
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      final_report();
   end

   initial begin
      tx_low = 1'b0;
      rx_low = 1'b0;
      dir_at_start = 1'b0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      step(1);
      chk({rts_n_q, dtr_n_q, tx_led, rx_led, transceiver_dir, clk_out_q}, 6'b01_1100);
      rd(ufc_pkg::OFF_HWMARK, v);
      chk(v, 32'h0180_01C0);
      rd(ufc_pkg::OFF_XCHAR, v);
      chk(v, 32'h0000_1311);
      rd(8'h30, v);
      chk(v, 32'h0000_0000);
      $display("test reset done");
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0001);
      foreach (lv[i]) begin
         @(posedge clk);
         rx_level <= lv[i];
         step(3);
         chk(rts_n_q, rts_exp[i]);
      end
      wr(ufc_pkg::OFF_HWMARK, 32'h0008_0010);
      @(posedge clk);
      rx_level <= 10'h010;
      step(3);
      chk(rts_n_q, 1);
      @(posedge clk);
      rx_level <= 10'h000;
      $display("test hw flow done");
      foreach (xl[i]) begin
         wr(ufc_pkg::OFF_XLIM, xl[i]);
         rd(ufc_pkg::OFF_XEFF, v);
         chk(v, xe[i]);
      end
      wr(ufc_pkg::OFF_XLIM, 32'h00C0_00C0);
      $display("test limits done");
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0002);
      send_rx(8'h13);
      @(posedge clk);
      txq_data <= 8'hA5;
      txq_valid <= 1'b1;
      rx_level <= 10'h0C8;
      step(40);
      chk(tx_count, 0);
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0006);
      wait_tx(1);
      chk(tx_last, 8'h13);
      send_rx(8'h11);
      wait_tx(2);
      chk(tx_last, 8'hA5);
      @(posedge clk);
      txq_valid <= 1'b0;
      step(30);
      c = tx_count;
      @(posedge clk);
      rx_level <= 10'h000;
      wait_tx(c + 1);
      chk(tx_last, 8'h11);
      $display("test sw flow done");
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0001);
      c = tx_count;
      @(posedge clk);
      txq_data <= 8'h5A;
      txq_valid <= 1'b1;
      wait_tx(c + 1);
      wr(ufc_pkg::OFF_IMM, 32'h0000_007E);
      wait_tx(c + 2);
      chk(tx_last, 8'h7E);
      wait_tx(c + 3);
      chk(tx_last, 8'h5A);
      @(posedge clk);
      cts_n <= 1'b1;
      step(0);
      c = tx_count;
      step(80);
      chk(tx_count - c <= 2, 1);
      @(posedge clk);
      cts_n <= 1'b0;
      wait_tx(tx_count + 1);
      chk(tx_low, 1);
      @(posedge clk);
      txq_valid <= 1'b0;
      $display("test transmit done");
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0040);
      foreach (dv[i]) begin
         wr(ufc_pkg::OFF_CLKDIV, {24'h00_0000, dv[i]});
         edge_gap(n);
         chk(n, dv[i] + 1);
      end
      @(posedge clk);
      usb_suspend <= 1'b1;
      step(3);
      edge_gap(n);
      chk(n, 600);
      $display("test clock done");
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0200);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         usb_suspend <= (i == 0);
         remote_wake_n <= 1'b1;
         step(5);
         @(posedge clk);
         remote_wake_n <= 1'b0;
         seen = 1'b0;
         repeat (8) begin
            step(1);
            if (wake_req_q === 1'b1) seen = 1'b1;
         end
         chk(seen, i == 0);
      end
      $display("test wakeup done");
      rx_low = 1'b0;
      send_rx(8'h42);
      step(6);
      chk(rx_low, 1);
      step(40);
      chk({tx_led, rx_led}, 2'b11);
      @(posedge clk);
      evt_req <= 1'b1;
      rx_level <= 10'h200;
      @(posedge clk);
      evt_req <= 1'b0;
      step(4);
      chk(evt_post_q, 0);
      @(posedge clk);
      rx_level <= 10'h000;
      step(1);
      chk(evt_post_q, 1);
      $display("test activity done");
      for (int i = 0; i < 2; i++) begin
         wr(ufc_pkg::OFF_CTRL, i ? 32'h0000_0180 : 32'h0000_0100);
         step(4);
         chk(dtr_n_q, i == 0);
         rd(ufc_pkg::OFF_STAT, v);
         chk(v[7], i == 1);
      end
      $display("test modem done");
      for (int i = 0; i < 2; i++) begin
         wr(ufc_pkg::OFF_BAUD, i ? 32'h0000_0258 : 32'h0001_C200);
         wr(ufc_pkg::OFF_CTRL, 32'h0000_0010);
         dir_at_start = (i == 1);
         c = tx_count;
         @(posedge clk);
         txq_valid <= 1'b1;
         wait_tx(c + 1);
         @(posedge clk);
         txq_valid <= 1'b0;
         chk(dir_at_start, i == 0);
      end
      wr(ufc_pkg::OFF_BAUD, 32'h0001_C200);
      wr(ufc_pkg::OFF_CTRL, 32'h0000_0030);
      step(40);
      chk(transceiver_dir, 1);
      $display("test dir done");
      for (int i = 0; i < 2; i++) begin
         wr(ufc_pkg::OFF_BAUD, i ? 32'h0000_016E : 32'h0000_016D);
         step(3);
         chk(prescale4_q, i == 0);
      end
      $display("test prescale done");
      final_report();
   end
endmodule : ufc_top_bench
